// ===== core/ulb_core.v
`timescale 1ns/100ps
`include "ulb_regs.vh"

module ulb_core (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       rx_line,
    output reg        tx_line,
    output reg        tx_done_irq,
    output reg        rx_done_irq,
    output reg        rx_error_irq
);

    localparam TX_IDLE  = 3'b001;
    localparam TX_FRAME = 3'b010;
    localparam TX_BREAK = 3'b100;
    localparam RX_IDLE  = 3'b001;
    localparam RX_START = 3'b010;
    localparam RX_DATA  = 3'b100;

    reg  [7:0]  uart_mode_reg;
    reg         break_rx_flag;
    reg         break_rx_enable;
    reg         break_tx_trigger;
    reg  [2:0]  break_length_sel;
    reg  [3:0]  base_clock_sel;
    reg  [7:0]  baud_divisor;
    reg         overrun_flag;
    reg         framing_error_flag;
    reg         parity_error_flag;
    reg  [7:0]  tx_buffer;
    reg         tx_buf_full;
    reg  [7:0]  rx_buffer;
    reg         rx_buf_full;
    reg  [9:0]  pre_cnt;
    reg         rx_s1;
    reg         rx_s2;
    reg         rx_samp;
    reg         rx_filt;
    reg         rx_prev;
    reg  [2:0]  tx_state;
    reg  [7:0]  tx_cnt;
    reg         tx_half;
    reg  [10:0] tx_sh;
    reg  [4:0]  tx_bitno;
    reg  [2:0]  rx_state;
    reg  [7:0]  rx_cnt;
    reg         rx_half;
    reg  [3:0]  rx_bitno;
    reg  [7:0]  rx_shift;
    reg         rx_par;
    reg  [3:0]  rx_low;
    reg         rx_brk_mode;

    wire        unit_power_on = uart_mode_reg[`ULB_MODE_POWER];
    wire        tx_enable_bit = uart_mode_reg[`ULB_MODE_TXEN];
    wire        rx_enable_bit = uart_mode_reg[`ULB_MODE_RXEN];
    wire [1:0]  par_mode      = uart_mode_reg[`ULB_MODE_PAR_HI:`ULB_MODE_PAR_LO];
    wire        error_irq_merge = uart_mode_reg[`ULB_MODE_MERGE];
    wire        tx_on = unit_power_on & tx_enable_bit;
    wire        rx_on = unit_power_on & rx_enable_bit;
    wire [2:0]  rx_error_status = {parity_error_flag, framing_error_flag, overrun_flag};

    // Base clock tick: low bits of the prescaler all ones; none while unpowered
    wire [9:0]  pre_mask = ~(10'h3ff << base_clock_sel);
    wire        base_tick = unit_power_on & (base_clock_sel <= `ULB_PRE_MAXSEL) &
                            ((pre_cnt & pre_mask) == pre_mask);
    wire [7:0]  div_last = baud_divisor - 8'h01;

    // Transmit timing
    wire        tx_match   = base_tick & (tx_cnt == div_last);
    wire        tx_bit_end = tx_match & tx_half;
    wire [3:0]  tx_nbits   = (par_mode == 2'h0) ? 4'ha : 4'hb;
    wire        tx_last    = (tx_bitno == {1'b0, tx_nbits - 4'h1});
    wire [4:0]  brk_last   = `ULB_BRK_TX_BASE + {2'h0, break_length_sel};
    wire        tx_start_frame = tx_on & tx_state[0] & tx_buf_full & base_tick;
    wire        tx_chain   = tx_on & tx_state[1] & tx_bit_end & tx_last & tx_buf_full;
    wire        tx_load    = tx_start_frame | tx_chain;
    wire        tx_brk_end = tx_on & tx_state[2] & tx_bit_end & (tx_bitno == brk_last);
    wire        tx_par     = (par_mode == 2'h2) ? ~^tx_buffer :
                             (par_mode == 2'h3) ? ^tx_buffer : 1'b0;
    wire [10:0] tx_frame   = (par_mode == 2'h0) ? {2'h3, tx_buffer, 1'b0} :
                                                  {1'b1, tx_par, tx_buffer, 1'b0};

    // Receive timing
    wire        rx_match   = base_tick & (rx_cnt == div_last);
    wire        rx_bit_end = rx_match & rx_half;
    wire        rx_has_par = (par_mode != 2'h0);
    wire [3:0]  rx_stop_no = rx_has_par ? 4'h9 : 4'h8;
    wire        rx_norm_end = rx_on & rx_state[2] & rx_bit_end & ~rx_brk_mode & (rx_bitno == rx_stop_no);
    wire        rx_brk_stop = rx_on & rx_state[2] & rx_bit_end & rx_brk_mode & rx_filt;
    wire        rx_brk_ok  = rx_brk_stop & (rx_low >= `ULB_BRK_RX_MIN);
    wire        rx_brk_go  = rx_on & rx_state[1] & rx_match & ~rx_filt & break_rx_enable;
    wire        par_calc   = ^{rx_shift, rx_par};
    wire        pe_hit = rx_norm_end & ((par_mode == 2'h2) & ~par_calc |
                                        (par_mode == 2'h3) & par_calc);
    wire        fe_hit = rx_norm_end & ~rx_filt;
    wire        ove_hit = rx_norm_end & rx_buf_full;
    wire        any_err = pe_hit | fe_hit | ove_hit;

    wire        wr_mode = reg_wr & (reg_addr == `ULB_OFS_MODE);
    wire        wr_ctrl = reg_wr & (reg_addr == `ULB_OFS_CTRL);
    wire        rd_err  = reg_rd & (reg_addr == `ULB_OFS_ERR);
    wire        rd_rxb  = reg_rd & (reg_addr == `ULB_OFS_RXBUF);
    wire        wr_txb  = reg_wr & (reg_addr == `ULB_OFS_TXBUF);

    // Register file
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            uart_mode_reg      <= `ULB_RST_MODE;
            break_rx_flag      <= 1'b0;
            break_rx_enable    <= 1'b0;
            break_tx_trigger   <= 1'b0;
            break_length_sel   <= 3'h0;
            base_clock_sel     <= `ULB_RST_CLKSEL;
            baud_divisor       <= `ULB_RST_DIV;
            overrun_flag       <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag  <= 1'b0;
            tx_buffer          <= 8'h00;
            tx_buf_full        <= 1'b0;
            rx_buffer          <= `ULB_RST_RXBUF;
            rx_buf_full        <= 1'b0;
        end
        else
        begin
            if (wr_mode)
                uart_mode_reg <= reg_wdata;
            if (reg_wr & (reg_addr == `ULB_OFS_CLKSEL))
                base_clock_sel <= reg_wdata[3:0];
            if (reg_wr & (reg_addr == `ULB_OFS_DIV))
                baud_divisor <= reg_wdata;
            if (wr_ctrl)
            begin
                break_length_sel <= reg_wdata[`ULB_CTRL_LEN_HI:`ULB_CTRL_LEN_LO];
                break_tx_trigger <= reg_wdata[`ULB_CTRL_BTRIG] & tx_on;
                break_rx_enable  <= reg_wdata[`ULB_CTRL_BREN];
            end
            else
            begin
                if (tx_brk_end)
                    break_tx_trigger <= 1'b0;
                if (rx_brk_ok)
                    break_rx_enable <= 1'b0;
            end
            if (rx_brk_go)
                break_rx_flag <= 1'b1;
            else if (rx_brk_ok | ~rx_on)
                break_rx_flag <= 1'b0;
            // Error flags: a new error wins over the read clear
            overrun_flag       <= (overrun_flag & ~rd_err) | ove_hit;
            framing_error_flag <= (framing_error_flag & ~rd_err) | fe_hit;
            parity_error_flag  <= (parity_error_flag & ~rd_err) | pe_hit;
            if (wr_txb)
                tx_buffer <= reg_wdata;
            if (wr_txb)
                tx_buf_full <= 1'b1;
            else if (tx_load | ~tx_on)
                tx_buf_full <= 1'b0;
            if (rx_norm_end & ~ove_hit)
                rx_buffer <= rx_shift;
            if (rx_norm_end & ~ove_hit)
                rx_buf_full <= 1'b1;
            else if (rd_rxb)
                rx_buf_full <= 1'b0;
        end
    end

    // Read data valid in the cycle after the strobe only
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `ULB_OFS_MODE:   reg_rdata <= uart_mode_reg;
                `ULB_OFS_CTRL:   reg_rdata <= {break_rx_flag, break_rx_enable, break_tx_trigger,
                                               break_length_sel, 2'h0};
                `ULB_OFS_ERR:    reg_rdata <= {5'h00, rx_error_status};
                `ULB_OFS_CLKSEL: reg_rdata <= {4'h0, base_clock_sel};
                `ULB_OFS_DIV:    reg_rdata <= baud_divisor;
                `ULB_OFS_TXBUF:  reg_rdata <= tx_buffer;
                `ULB_OFS_RXBUF:  reg_rdata <= rx_buffer;
                default:         reg_rdata <= {6'h00, tx_buf_full, ~tx_state[0]};
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // Prescaler, synchroniser and noise filter
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_cnt <= 10'h000;
            rx_s1   <= 1'b1;
            rx_s2   <= 1'b1;
            rx_samp <= 1'b1;
            rx_filt <= 1'b1;
            rx_prev <= 1'b1;
        end
        else
        begin
            pre_cnt <= unit_power_on ? pre_cnt + 10'h001 : 10'h000;
            rx_s1   <= rx_line;
            rx_s2   <= rx_s1;
            if (base_tick)
            begin
                rx_samp <= rx_s2;
                rx_prev <= rx_filt;
                if (rx_samp == rx_s2)
                    rx_filt <= rx_samp;
            end
        end
    end

    // Transmitter and its counter
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state    <= TX_IDLE;
            tx_cnt      <= 8'h00;
            tx_half     <= 1'b0;
            tx_sh       <= 11'h7ff;
            tx_bitno    <= 5'h00;
            tx_line     <= 1'b1;
            tx_done_irq <= 1'b0;
        end
        else if (!tx_on)
        begin
            tx_state    <= TX_IDLE;
            tx_cnt      <= 8'h00;
            tx_half     <= 1'b0;
            tx_bitno    <= 5'h00;
            tx_line     <= 1'b1;
            tx_done_irq <= 1'b0;
        end
        else
        begin
            tx_done_irq <= 1'b0;
            if (tx_load | (tx_state[0] & break_tx_trigger))
            begin
                tx_cnt  <= 8'h00;
                tx_half <= 1'b0;
            end
            else if (tx_match)
            begin
                tx_cnt  <= 8'h00;
                tx_half <= ~tx_half;
            end
            else if (base_tick)
                tx_cnt <= tx_cnt + 8'h01;
            case (tx_state)
                TX_IDLE:
                begin
                    tx_bitno <= 5'h00;
                    // Start only on a base tick so the first bit is a whole bit time
                    if (tx_buf_full & base_tick)
                    begin
                        tx_sh    <= tx_frame;
                        tx_line  <= 1'b0;
                        tx_state <= TX_FRAME;
                    end
                    else if (break_tx_trigger & base_tick)
                    begin
                        tx_line  <= 1'b0;
                        tx_state <= TX_BREAK;
                    end
                    else
                        tx_line <= 1'b1;
                end
                TX_FRAME:
                begin
                    if (tx_bit_end)
                    begin
                        if (tx_last)
                        begin
                            tx_done_irq <= 1'b1;
                            tx_bitno    <= 5'h00;
                            if (tx_buf_full)
                            begin
                                tx_sh   <= tx_frame;
                                tx_line <= 1'b0;
                            end
                            else
                            begin
                                tx_line  <= 1'b1;
                                tx_state <= TX_IDLE;
                            end
                        end
                        else
                        begin
                            tx_sh    <= {1'b1, tx_sh[10:1]};
                            tx_line  <= tx_sh[1];
                            tx_bitno <= tx_bitno + 5'h01;
                        end
                    end
                end
                TX_BREAK:
                begin
                    if (tx_brk_end)
                    begin
                        tx_line     <= 1'b1;
                        tx_done_irq <= 1'b1;
                        tx_state    <= TX_IDLE;
                    end
                    else if (tx_bit_end)
                        tx_bitno <= tx_bitno + 5'h01;
                end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // Receiver and its counter
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state     <= RX_IDLE;
            rx_cnt       <= 8'h00;
            rx_half      <= 1'b0;
            rx_bitno     <= 4'h0;
            rx_shift     <= 8'hff;
            rx_par       <= 1'b0;
            rx_low       <= 4'h0;
            rx_brk_mode  <= 1'b0;
            rx_done_irq  <= 1'b0;
            rx_error_irq <= 1'b0;
        end
        else if (!rx_on)
        begin
            rx_state     <= RX_IDLE;
            rx_cnt       <= 8'h00;
            rx_half      <= 1'b0;
            rx_done_irq  <= 1'b0;
            rx_error_irq <= 1'b0;
        end
        else
        begin
            rx_done_irq  <= rx_brk_ok | (rx_norm_end & (~any_err | error_irq_merge));
            rx_error_irq <= any_err & ~error_irq_merge;
            if (rx_state[0])
            begin
                rx_cnt  <= 8'h00;
                rx_half <= 1'b0;
            end
            else if (rx_match)
            begin
                rx_cnt  <= 8'h00;
                rx_half <= ~rx_half & ~rx_state[1];
            end
            else if (base_tick)
                rx_cnt <= rx_cnt + 8'h01;
            case (rx_state)
                RX_IDLE:
                begin
                    if (base_tick & rx_prev & ~rx_filt)
                        rx_state <= RX_START;
                end
                RX_START:
                begin
                    if (rx_match)
                    begin
                        rx_bitno    <= 4'h0;
                        rx_low      <= 4'h1;
                        rx_brk_mode <= break_rx_enable;
                        rx_state    <= rx_filt ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (rx_bit_end)
                    begin
                        if (rx_brk_mode)
                        begin
                            // Measure the low width; errors and buffer untouched
                            if (rx_filt)
                                rx_state <= RX_IDLE;
                            else if (rx_low != 4'hf)
                                rx_low <= rx_low + 4'h1;
                        end
                        else if (rx_norm_end)
                            rx_state <= RX_IDLE;
                        else
                        begin
                            if (rx_bitno[3])
                                rx_par <= rx_filt;
                            else
                                rx_shift <= {rx_filt, rx_shift[7:1]};
                            rx_bitno <= rx_bitno + 4'h1;
                        end
                    end
                end
                default:
                    rx_state <= RX_IDLE;
            endcase
        end
    end

endmodule // ulb_core

// ===== core/ulb_regs.vh
`ifndef ULB_REGS_VH
`define ULB_REGS_VH

// Register offsets on the 3-bit register port
`define ULB_OFS_MODE     3'h0
`define ULB_OFS_CTRL     3'h1
`define ULB_OFS_ERR      3'h2
`define ULB_OFS_CLKSEL   3'h3
`define ULB_OFS_DIV      3'h4
`define ULB_OFS_TXBUF    3'h5
`define ULB_OFS_RXBUF    3'h6
`define ULB_OFS_TXSTAT   3'h7

// Mode register fields
`define ULB_MODE_POWER   7
`define ULB_MODE_TXEN    6
`define ULB_MODE_RXEN    5
`define ULB_MODE_PAR_HI  4
`define ULB_MODE_PAR_LO  3
`define ULB_MODE_MERGE   0

// Control register fields
`define ULB_CTRL_BRFLAG  7
`define ULB_CTRL_BREN    6
`define ULB_CTRL_BTRIG   5
`define ULB_CTRL_LEN_HI  4
`define ULB_CTRL_LEN_LO  2

// Error status fields
`define ULB_ERR_OVE      0
`define ULB_ERR_FE       1
`define ULB_ERR_PE       2

// Reset values
`define ULB_RST_MODE     8'h01
`define ULB_RST_CTRL     8'h00
`define ULB_RST_CLKSEL   4'h0
`define ULB_RST_DIV      8'hff
`define ULB_RST_RXBUF    8'hff

// Break and prescaler figures
`define ULB_BRK_TX_BASE  5'h0c
`define ULB_BRK_RX_MIN   4'hb
`define ULB_PRE_MAXSEL   4'ha

`endif

// ===== verification/ulb_core_props.sv
`timescale 1ns/100ps
`include "ulb_regs.vh"

module ulb_core_props (
    input wire       mclk,
    input wire       rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       rx_line,
    input wire       tx_line,
    input wire       tx_done_irq,
    input wire       rx_done_irq,
    input wire       rx_error_irq
);
    wire irq = rx_done_irq | rx_error_irq;
    reg  err_pend;
    reg  rx_seen;

    // Remembers whether a reception may have left anything in the error status
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_pend <= 1'b0;
            rx_seen  <= 1'b0;
        end
        else
        begin
            err_pend <= irq | (err_pend & ~(reg_rd & (reg_addr == `ULB_OFS_ERR)));
            rx_seen  <= rx_seen | irq;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_irq_excl; !(rx_done_irq && rx_error_irq); endproperty
    a_irq_excl: assert property (p_irq_excl) else $error("receive irqs overlap");
    property p_tx_low_min; $fell(tx_line) |-> !tx_line [*8]; endproperty
    a_tx_low_min: assert property (p_tx_low_min) else $error("tx low shorter than a bit");
    property p_txdone_line; tx_done_irq |-> tx_line || $past(tx_line); endproperty
    a_txdone_line: assert property (p_txdone_line) else $error("tx done while line low");
    property p_txdone_gap; tx_done_irq |=> !tx_done_irq [*8]; endproperty
    a_txdone_gap: assert property (p_txdone_gap) else $error("tx done too close");
    property p_rxerr_gap; rx_error_irq |=> !rx_error_irq [*8]; endproperty
    a_rxerr_gap: assert property (p_rxerr_gap) else $error("error irq too close");
    property p_err_clear;
        reg_rd && reg_addr == `ULB_OFS_ERR && !err_pend && !irq |=> reg_rdata == 8'h00;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error status not cleared");
    property p_rxbuf_reset;
        reg_rd && reg_addr == `ULB_OFS_RXBUF && !rx_seen && !irq |=> reg_rdata == `ULB_RST_RXBUF;
    endproperty
    a_rxbuf_reset: assert property (p_rxbuf_reset) else $error("receive buffer lost reset value");
    property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    c_txd: cover property (tx_done_irq);
    c_rxd: cover property (rx_done_irq);
    c_rxe: cover property (rx_error_irq);
endmodule // ulb_core_props

bind ulb_core ulb_core_props u_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line(rx_line), .tx_line(tx_line),
    .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));

// ===== verification/ulb_remote_node.sv
`timescale 1ns/100ps

module ulb_remote_node #(
    parameter int BIT_CYC = 8
) (
    input  wire  mclk,
    input  wire  tx_line,
    output logic rx_line
);
    initial rx_line = 1'b1;

    task automatic hold(input logic v, input int n);
        rx_line <= v;
        repeat (n) @(posedge mclk);
    endtask

    // Start, eight data bits LSB first, optional parity, one stop bit
    task automatic send_frame(input logic [7:0] d, input logic par_on, input logic par_b, input logic stop_b);
        @(posedge mclk);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < 8; i++)
            hold(d[i], BIT_CYC);
        if (par_on)
            hold(par_b, BIT_CYC);
        hold(stop_b, BIT_CYC);
        hold(1'b1, 3 * BIT_CYC);
    endtask

    // Low level of n clock cycles, then idle
    task automatic send_low(input int n);
        @(posedge mclk);
        hold(1'b0, n);
        hold(1'b1, 4 * BIT_CYC);
    endtask

    task automatic wait_fall();
        for (int w = 0; w < 3000 && tx_line !== 1'b0; w++)
            @(posedge mclk);
    endtask

    task automatic measure_low(output int n);
        n = 0;
        wait_fall();
        while (tx_line === 1'b0 && n < 400)
        begin
            n++;
            @(posedge mclk);
        end
    endtask

    task automatic recv_byte(output logic [7:0] d, output logic stop_b);
        d = 8'hxx;
        wait_fall();
        repeat (BIT_CYC / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge mclk);
            d[i] = tx_line;
        end
        repeat (BIT_CYC) @(posedge mclk);
        stop_b = tx_line;
    endtask
endmodule // ulb_remote_node

// ===== verification/ulb_core_tb_top.sv
`timescale 1ns/100ps
`include "ulb_regs.vh"
`define ULB_CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end

module ulb_core_tb_top;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    wire  [7:0] reg_rdata;
    wire        rx_line;
    wire        tx_line;
    wire        tx_done_irq;
    wire        rx_done_irq;
    wire        rx_error_irq;
    int         n_errors = 0;
    int         n_compared = 0;
    int         n_cyc = 0;
    int         n_txd = 0;
    int         n_rxd = 0;
    int         n_rxe = 0;
    int         nlow;
    logic [7:0] b0;
    logic [7:0] b1;
    logic       s0;
    logic       s1;

    ulb_core uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line(rx_line), .tx_line(tx_line),
        .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
    ulb_remote_node #(.BIT_CYC(8)) u_node (.mclk(mclk), .tx_line(tx_line), .rx_line(rx_line));

    always #2 mclk = ~mclk;

    // Pulse counts, taken on the falling edge away from the design's updates
    always @(negedge mclk)
    begin
        n_cyc++;
        n_txd += (tx_done_irq === 1'b1);
        n_rxd += (rx_done_irq === 1'b1);
        n_rxe += (rx_error_irq === 1'b1);
        if (n_cyc == 20000)
        begin
            n_errors++;
            close_out();
        end
    end

    task close_out();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task chk_rd(input string nm, input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        `ULB_CHK(nm, exp, reg_rdata)
    endtask

    task clr();
        @(posedge mclk);
        n_txd = 0;
        n_rxd = 0;
        n_rxe = 0;
    endtask

    task wait_rx();
        for (int i = 0; i < 200 && n_rxd + n_rxe == 0; i++)
            @(posedge mclk);
        repeat (16) @(posedge mclk);
    endtask

    task t_reset();
        chk_rd("mode", `ULB_OFS_MODE, `ULB_RST_MODE);
        chk_rd("ctrl", `ULB_OFS_CTRL, `ULB_RST_CTRL);
        chk_rd("clksel", `ULB_OFS_CLKSEL, {4'h0, `ULB_RST_CLKSEL});
        chk_rd("div", `ULB_OFS_DIV, `ULB_RST_DIV);
        chk_rd("rxbuf", `ULB_OFS_RXBUF, `ULB_RST_RXBUF);
        wr(`ULB_OFS_ERR, 8'h07);
        chk_rd("err", `ULB_OFS_ERR, 8'h00);
        wr(`ULB_OFS_CTRL, 8'h20);
        chk_rd("trig unpowered", `ULB_OFS_CTRL, 8'h00);
    endtask

    task t_setup();
        wr(`ULB_OFS_DIV, 8'h04);
        wr(`ULB_OFS_CLKSEL, 8'h00);
        wr(`ULB_OFS_MODE, 8'he0);
        chk_rd("div", `ULB_OFS_DIV, 8'h04);
        `ULB_CHK("tx powered", 1'b1, tx_line)
    endtask

    task t_brk_rx();
        clr();
        wr(`ULB_OFS_CTRL, 8'h40);
        u_node.send_low(80);
        repeat (16) @(posedge mclk);
        `ULB_CHK("short brk irq", 0, n_rxd + n_rxe)
        chk_rd("short brk ctrl", `ULB_OFS_CTRL, 8'hc0);
        u_node.send_low(88);
        wait_rx();
        `ULB_CHK("brk done", 1, n_rxd)
        `ULB_CHK("brk error irq", 0, n_rxe)
        chk_rd("brk ctrl", `ULB_OFS_CTRL, 8'h00);
        chk_rd("brk err", `ULB_OFS_ERR, 8'h00);
        chk_rd("brk rxbuf", `ULB_OFS_RXBUF, `ULB_RST_RXBUF);
    endtask

    task rx_case(input string nm, input logic [7:0] d, input logic [1:0] par, input logic stop_b,
                 input int rxd, input int rxe, input logic [7:0] err, input logic [7:0] bv);
        clr();
        u_node.send_frame(d, par[1], par[0], stop_b);
        wait_rx();
        `ULB_CHK(nm, rxd, n_rxd)
        `ULB_CHK(nm, rxe, n_rxe)
        chk_rd(nm, `ULB_OFS_ERR, err);
        chk_rd(nm, `ULB_OFS_ERR, 8'h00);
        chk_rd(nm, `ULB_OFS_RXBUF, bv);
    endtask

    task t_rx();
        clr();
        u_node.send_low(1);
        repeat (100) @(posedge mclk);
        `ULB_CHK("glitch", 0, n_rxd + n_rxe)
        rx_case("good", 8'ha5, 2'b00, 1'b1, 1, 0, 8'h00, 8'ha5);
        u_node.send_frame(8'h3c, 1'b0, 1'b0, 1'b1);
        rx_case("overrun", 8'hc3, 2'b00, 1'b1, 0, 1, 8'h01, 8'h3c);
        rx_case("framing", 8'h55, 2'b00, 1'b0, 0, 1, 8'h02, 8'h55);
        wr(`ULB_OFS_MODE, 8'hf8);
        rx_case("parity", 8'h01, 2'b10, 1'b1, 0, 1, 8'h04, 8'h01);
        wr(`ULB_OFS_MODE, 8'he1);
        rx_case("merged", 8'h55, 2'b00, 1'b0, 1, 0, 8'h02, 8'h55);
    endtask

    task t_tx();
        clr();
        fork
            u_node.recv_byte(b0, s0);
            wr(`ULB_OFS_TXBUF, 8'h3c);
        join
        `ULB_CHK("tx byte", 8'h3c, b0)
        fork
            begin
                u_node.recv_byte(b0, s0);
                u_node.recv_byte(b1, s1);
            end
            begin
                wr(`ULB_OFS_TXBUF, 8'ha5);
                wr(`ULB_OFS_TXBUF, 8'h5a);
            end
        join
        repeat (16) @(posedge mclk);
        `ULB_CHK("tx first", 8'ha5, b0)
        `ULB_CHK("tx second", 8'h5a, b1)
        `ULB_CHK("tx stop", 1'b1, s1)
        `ULB_CHK("tx done count", 3, n_txd)
        clr();
        wr(`ULB_OFS_MODE, 8'ha1);
        wr(`ULB_OFS_TXBUF, 8'h11);
        wr(`ULB_OFS_MODE, 8'he1);
        repeat (120) @(posedge mclk);
        `ULB_CHK("tx disabled", 0, n_txd)
        `ULB_CHK("tx disabled line", 1'b1, tx_line)
    endtask

    task t_brk_tx();
        for (int len = 0; len < 8; len++)
        begin
            clr();
            fork
                u_node.measure_low(nlow);
                wr(`ULB_OFS_CTRL, {3'b001, len[2:0], 2'b00});
            join
            `ULB_CHK("brk width", (13 + len) * 8, nlow)
            repeat (40) @(posedge mclk);
            `ULB_CHK("brk tx done", 1, n_txd)
            `ULB_CHK("brk idle", 1'b1, tx_line)
            chk_rd("brk trig", `ULB_OFS_CTRL, {3'b000, len[2:0], 2'b00});
        end
        wr(`ULB_OFS_CLKSEL, 8'h01);
        fork
            u_node.measure_low(nlow);
            wr(`ULB_OFS_CTRL, 8'h20);
        join
        `ULB_CHK("slow brk width", 13 * 16, nlow)
    endtask

    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_setup();
        t_brk_rx();
        t_rx();
        t_tx();
        t_brk_tx();
        close_out();
    end
endmodule // ulb_core_tb_top
